// ==== rtl/poly_counter.sv ====
`timescale 1ns/1ps
`include "seq_params.svh"
module poly_counter
(
    input  wire logic [`ADDR_W-1:0] cur,
    output logic      [`ADDR_W-1:0] nxt
);
    // shift left, feedback bit5 xnor bit4 (63->62->61->59...->0->1->3);
    // plain xnor feedback locks up at 63, the low-ones term splices it in
    always_comb
    begin
        nxt = {cur[`ADDR_W-2:0], ~(cur[5] ^ cur[4]) ^ (&cur[4:0])};
    end
endmodule

// ==== rtl/program_sequencer_branch_unit.sv ====
// Summary of operation
// - pattern address: A and B[1:0] replace address; B[3:2], carry, p ORed up.
// - operand p is 3 bits; its MSB is ORed with the current bank bit.
// - fetch from bank 1 reads bank 1; from bank 0 bank follows p MSB.
// - pattern fetch leaves counter; it then advances to next instruction.
// - pattern fetch takes exactly two instruction cycles.
// - acc flag loads A and B; port flag loads port regs; both do both.
// - rom word is 10 bits, split 2, 4, 4 from the top.
// - local_jump copies low six code bits to address, keeps bank and page.
// - local_jump/far_jump run only when status is 1, else skip, set it.
// - page_preload loads page from low five bits one cycle late.
// - at that moment bank takes inverted bank_select_bit.
// - old bank and page hold in the next cycle; new ones after.
// - page_preload runs only if status 1; skipped leaves status 0.
// - far_jump_macro is page_preload followed by local_jump.
// - table_jump loads counter from A, B, carry and p; bank ORs p MSB.
// - table_jump ignores and keeps the status flip-flop.
// - call pushes next address into slot one, shifting others down.
// - call sets bank 0, page 0, address from low six code bits.
// - return stack holds four levels.
// - call runs only if status 1, else skipped and status set.
// - address part is 6-bit polynomial counter, no carry into page.
// - bank and page hold until an instruction reloads them.
`timescale 1ns/1ps
`include "seq_params.svh"
module program_sequencer_branch_unit
    import seq_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  instr_valid,
    input  wire op_e                   instr_op,
    input  wire logic [`ROM_W-1:0]     instr_code,
    input  wire logic [`ROM_W-1:0]     rom_data,
    input  wire logic [3:0]            acc,
    input  wire logic [3:0]            breg,
    input  wire logic                  carry,
    input  wire logic                  bank_select_bit,
    input  wire logic                  status_in,
    input  wire logic                  status_load,
    output logic      [`PC_W-1:0]      rom_addr,
    output logic                       busy,
    output logic                       status,
    output logic                       acc_load,
    output logic      [3:0]            acc_value,
    output logic      [3:0]            breg_value,
    output logic                       port_load,
    output logic      [3:0]            port_reg_two,
    output logic      [3:0]            port_reg_three,
    output logic      [`PC_W-1:0]      return_slot_one,
    output logic      [`PC_W-1:0]      return_slot_two,
    output logic      [`PC_W-1:0]      return_slot_three,
    output logic      [`PC_W-1:0]      return_slot_four
);
    logic [`ADDR_W-1:0] addr_part;
    logic [`PAGE_W-1:0] page_part;
    logic               current_bank_bit;
    logic [`ADDR_W-1:0] next_addr;
    seq_state_e         state;
    logic               preload_pend;
    logic [`PAGE_W-1:0] preload_page;
    logic               preload_bank;
    logic [`PC_W-1:0]   formed_addr;
    logic               do_exec;
    logic [`PC_W-1:0]   pc_next_word;
    logic [`ADDR_W-1:0] next_addr_part;
    logic [`PAGE_W-1:0] next_page_part;
    logic               next_bank;

    // the counter sequence lives in the small leaf
    poly_counter u_poly
    (
        .cur (addr_part),
        .nxt (next_addr)
    );

    assign do_exec = instr_valid && state == ST_RUN;
    assign pc_next_word = {current_bank_bit, page_part, next_addr};

    // shared by pattern fetch and table_jump
    always_comb
    begin
        formed_addr = {current_bank_bit | instr_code[2],
                       page_part | {instr_code[1:0], carry, breg[3:2]},
                       breg[1:0], acc};
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= ST_RUN;
        end
        else if (do_exec && instr_op == OP_PATTERN)
        begin
            state <= ST_FETCH;
        end
        else
        begin
            state <= ST_RUN;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            busy <= 1'b0;
        end
        else
        begin
            busy <= do_exec && instr_op == OP_PATTERN;
        end
    end

    // status flip-flop; the conditional skips win over an alu status write
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            status <= `STATUS_RESET;
        end
        else if (do_exec && !status &&
                 (instr_op == OP_LOCAL || instr_op == OP_CALL))
        begin
            status <= 1'b1;
        end
        else if (do_exec && instr_op == OP_PRELOAD && !status)
        begin
            status <= 1'b0;
        end
        else if (status_load && !(do_exec && instr_op == OP_TABLE))
        begin
            status <= status_in;
        end
    end

    // delayed page and bank load
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            preload_pend <= 1'b0;
            preload_page <= `PAGE_RESET;
            preload_bank <= `BANK_RESET;
        end
        else if (do_exec && instr_op == OP_PRELOAD && status)
        begin
            preload_pend <= 1'b1;
            preload_page <= instr_code[`PAGE_W-1:0];
            preload_bank <= ~bank_select_bit;
        end
        else
        begin
            preload_pend <= 1'b0;
        end
    end

    // next address part; the counter and rom_addr both load it, so a jump
    // reaches the rom bus in the very next cycle
    always_comb
    begin
        next_addr_part = next_addr;
        if (do_exec && status &&
            (instr_op == OP_LOCAL || instr_op == OP_CALL))
        begin
            next_addr_part = instr_code[`ADDR_W-1:0];
        end
        else if (do_exec && instr_op == OP_TABLE)
        begin
            next_addr_part = formed_addr[`ADDR_W-1:0];
        end
        else if (do_exec && instr_op == OP_PATTERN)
        begin
            next_addr_part = addr_part;
        end
    end

    // bank and page; a call overrides a pending preload, far jump follows it
    always_comb
    begin
        next_page_part = page_part;
        next_bank      = current_bank_bit;
        if (do_exec && status && instr_op == OP_CALL)
        begin
            next_page_part = '0;
            next_bank      = 1'b0;
        end
        else if (preload_pend)
        begin
            next_page_part = preload_page;
            next_bank      = preload_bank;
        end
        else if (do_exec && instr_op == OP_TABLE)
        begin
            next_page_part = formed_addr[`PC_W-2:`ADDR_W];
            next_bank      = formed_addr[`PC_W-1];
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            addr_part        <= `ADDR_RESET;
            page_part        <= `PAGE_RESET;
            current_bank_bit <= `BANK_RESET;
        end
        else
        begin
            addr_part        <= next_addr_part;
            page_part        <= next_page_part;
            current_bank_bit <= next_bank;
        end
    end

    // rom address: formed address during the fetch cycle, else next counter
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rom_addr <= {`BANK_RESET, `PAGE_RESET, `ADDR_RESET};
        end
        else if (do_exec && instr_op == OP_PATTERN)
        begin
            rom_addr <= formed_addr;
        end
        else
        begin
            rom_addr <= {next_bank, next_page_part, next_addr_part};
        end
    end

    // pattern decode during the second cycle
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            acc_load       <= 1'b0;
            port_load      <= 1'b0;
            acc_value      <= 4'h0;
            breg_value     <= 4'h0;
            port_reg_two   <= 4'h0;
            port_reg_three <= 4'h0;
        end
        else
        begin
            acc_load  <= state == ST_FETCH && rom_data[`CMD_ACC_BIT];
            port_load <= state == ST_FETCH && rom_data[`CMD_PORT_BIT];
            if (state == ST_FETCH && rom_data[`CMD_ACC_BIT])
            begin
                breg_value <= rom_data[7:4];
                acc_value  <= rom_data[3:0];
            end
            if (state == ST_FETCH && rom_data[`CMD_PORT_BIT])
            begin
                port_reg_two   <= rom_data[7:4];
                port_reg_three <= rom_data[3:0];
            end
        end
    end

    // four-level return stack, one generate stage per slot
    logic [`PC_W-1:0] slot [`STACK_DEPTH];
    genvar gi;
    generate
        for (gi = 0; gi < `STACK_DEPTH; gi++)
        begin : g_stack
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    slot[gi] <= '0;
                end
                else if (do_exec && status && instr_op == OP_CALL)
                begin
                    // the inner select keeps stage zero's index in range
                    slot[gi] <= (gi == 0) ? pc_next_word
                                          : slot[gi == 0 ? 0 : gi - 1];
                end
            end
        end
    endgenerate

    assign return_slot_one   = slot[0];
    assign return_slot_two   = slot[1];
    assign return_slot_three = slot[2];
    assign return_slot_four  = slot[3];

    fetch_two_cycle_a: assert property (@(posedge clk)
        disable iff (!rst_n)
        do_exec && instr_op == OP_PATTERN |=> busy ##1 !busy)
        else $error("pattern fetch not two cycles");
    fetch_keeps_pc_a: assert property (@(posedge clk)
        disable iff (!rst_n)
        do_exec && instr_op == OP_PATTERN |=> $stable(addr_part))
        else $error("pattern fetch moved counter");
    local_jump_a: assert property (@(posedge clk)
        disable iff (!rst_n)
        do_exec && status && instr_op == OP_LOCAL && !preload_pend
        |=> addr_part == $past(instr_code[5:0]) && $stable(page_part))
        else $error("local jump wrong");
    skip_sets_a: assert property (@(posedge clk)
        disable iff (!rst_n)
        do_exec && !status && instr_op == OP_LOCAL |=> status)
        else $error("skipped branch did not set status");
    preload_delay_a: assert property (@(posedge clk)
        disable iff (!rst_n)
        do_exec && status && instr_op == OP_PRELOAD ##1 !(do_exec &&
        status && instr_op == OP_CALL) |=> page_part ==
        $past(instr_code[4:0], 2) && current_bank_bit ==
        !$past(bank_select_bit, 2))
        else $error("preload not applied one cycle late");
    preload_skip_a: assert property (@(posedge clk)
        disable iff (!rst_n)
        do_exec && !status && instr_op == OP_PRELOAD |=> !status)
        else $error("skipped preload changed status");
    call_push_a: assert property (@(posedge clk)
        disable iff (!rst_n)
        do_exec && status && instr_op == OP_CALL |=> page_part == 5'h00
        && !current_bank_bit && slot[1] == $past(slot[0]))
        else $error("call push wrong");
    table_bank_a: assert property (@(posedge clk)
        disable iff (!rst_n)
        do_exec && instr_op == OP_TABLE && !preload_pend |=>
        current_bank_bit == ($past(current_bank_bit) | $past(instr_code[2])))
        else $error("table jump bank wrong");
endmodule

// ==== rtl/seq_params.svh ====
`ifndef SEQ_PARAMS_SVH
`define SEQ_PARAMS_SVH
`define ROM_W         10
`define ADDR_W        6
`define PAGE_W        5
`define PC_W          12
`define STACK_DEPTH   4
`define OPER_W        3
`define CMD_ACC_BIT   8
`define CMD_PORT_BIT  9
`define ADDR_RESET    6'h3f
`define PAGE_RESET    5'h00
`define BANK_RESET    1'b0
`define STATUS_RESET  1'b1
`define CLK_PERIOD_NS 4
`endif

// ==== rtl/seq_pkg.sv ====
package seq_pkg;
    typedef enum logic [2:0] {
        OP_NONE     = 3'h0,
        OP_PATTERN  = 3'h1,
        OP_LOCAL    = 3'h3,
        OP_PRELOAD  = 3'h2,
        OP_TABLE    = 3'h6,
        OP_CALL     = 3'h7
    } op_e;
    typedef enum logic [1:0] {
        ST_RUN   = 2'h0,
        ST_FETCH = 2'h1
    } seq_state_e;
endpackage

// ==== testbench/rom_model.sv ====
`timescale 1ns/1ps
module rom_model
(
    input  wire logic [11:0] rom_addr,
    input  wire logic        busy,
    output logic      [9:0]  rom_data
);
    // content follows the address so the bench can predict each word;
    // outside a fetch the word is scrambled so a stray sample shows up
    always_comb
    begin
        rom_data = {rom_addr[9:8], rom_addr[7:0] ^ 8'h5a};
        if (!busy)
            rom_data = ~rom_data;
    end
endmodule

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps
module tb_top
    import seq_pkg::*;
;
    typedef struct packed {
        op_e        op;
        logic [9:0] code;
        logic       c;
        logic [3:0] b;
        logic [3:0] a;
    } row_s;
    localparam row_s rows [6] = '{
        '{OP_PATTERN, 10'h001, 1'b0, 4'ha, 4'h0},
        '{OP_PATTERN, 10'h007, 1'b1, 4'h4, 4'h0},
        '{OP_PATTERN, 10'h000, 1'b0, 4'h0, 4'h0},
        '{OP_PATTERN, 10'h000, 1'b1, 4'h0, 4'h5},
        '{OP_TABLE,   10'h005, 1'b1, 4'h6, 4'h9},
        '{OP_LOCAL,   10'h02a, 1'b0, 4'h0, 4'h0}};
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        instr_valid = 1'b0;
    op_e         instr_op = OP_NONE;
    logic [9:0]  instr_code = 10'h000;
    logic [3:0]  acc = 4'h0;
    logic [3:0]  breg = 4'h0;
    logic        carry = 1'b0;
    logic        bank_select_bit = 1'b0;
    logic        status_in = 1'b0;
    logic        status_load = 1'b0;
    logic [9:0]  rom_data, w;
    logic [11:0] rom_addr, f;
    logic        busy, status, acc_load, port_load;
    logic [3:0]  acc_value, breg_value, port_reg_two, port_reg_three;
    logic [11:0] slot [4];
    logic [11:0] es [4] = '{12'h03e, 12'h03b, 12'h03d, 12'h03e};
    int          errors = 0;
    int          n_checks = 0;

    always #2 clk = ~clk;

    program_sequencer_branch_unit i_program_sequencer_branch_unit (
        .clk(clk), .rst_n(rst_n), .instr_valid(instr_valid),
        .instr_op(instr_op), .instr_code(instr_code), .rom_data(rom_data),
        .acc(acc), .breg(breg), .carry(carry),
        .bank_select_bit(bank_select_bit), .status_in(status_in),
        .status_load(status_load), .rom_addr(rom_addr), .busy(busy),
        .status(status), .acc_load(acc_load), .acc_value(acc_value),
        .breg_value(breg_value), .port_load(port_load),
        .port_reg_two(port_reg_two), .port_reg_three(port_reg_three),
        .return_slot_one(slot[0]), .return_slot_two(slot[1]),
        .return_slot_three(slot[2]), .return_slot_four(slot[3]));
    rom_model i_rom_model (.rom_addr(rom_addr), .busy(busy),
        .rom_data(rom_data));

    function automatic logic [11:0] form(input logic [11:0] pc,
        input logic [2:0] p, input logic c, input logic [3:0] b, a);
        form = {pc[11] | p[2], pc[10:6] | {p[1:0], c, b[3:2]}, b[1:0], a};
    endfunction

    task automatic chk(input string name, input logic [11:0] seen, exp);
        n_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED %0s exp %h seen %h", name, exp, seen);
        end
    endtask

    task automatic cyc(input logic v, input op_e op, input logic [9:0] code);
        instr_valid = v;
        instr_op = op;
        instr_code = code;
        @(posedge clk);
        #1;
    endtask

    task automatic do_reset;
        rst_n = 1'b0;
        repeat (8) @(posedge clk);
        #1;
        rst_n = 1'b1;
    endtask

    // both callers start from reset, so the held address is known
    task automatic far;
        bank_select_bit = 1'b0;
        cyc(1'b1, OP_PRELOAD, 10'h015);
        chk("hold", rom_addr, 12'h03e);
        cyc(1'b1, OP_LOCAL, 10'h03f);
        chk("far", rom_addr, 12'hd7f);
    endtask

    task automatic set_st0;
        status_load = 1'b1;
        cyc(1'b0, OP_NONE, 10'h000);
        status_load = 1'b0;
        chk("st0", status, 1'b0);
    endtask

    task automatic pat_chk;
        chk("busy_end", busy, 1'b0);
        chk("acc_load", acc_load, w[8]);
        chk("port_load", port_load, w[9]);
        if (w[8])
        begin
            chk("b", breg_value, w[7:4]);
            chk("a", acc_value, w[3:0]);
        end
        if (w[9])
        begin
            chk("p2", port_reg_two, w[7:4]);
            chk("p3", port_reg_three, w[3:0]);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        #40000;
        errors++;
        report_and_stop;
    end

    initial
    begin
        do_reset;
        chk("rst_pc", rom_addr, 12'h03f);
        chk("rst_st", status, 1'b1);
        foreach (rows[i])
        begin
            do_reset;
            acc = rows[i].a;
            breg = rows[i].b;
            carry = rows[i].c;
            f = form(12'h03f, rows[i].code[2:0], rows[i].c, rows[i].b,
                rows[i].a);
            w = {f[9:8], f[7:0] ^ 8'h5a};
            cyc(1'b1, rows[i].op, rows[i].code);
            if (rows[i].op == OP_LOCAL)
                chk("local", rom_addr, {6'h00, rows[i].code[5:0]});
            else
                chk("formed", rom_addr, f);
            if (rows[i].op == OP_PATTERN)
            begin
                chk("busy", busy, 1'b1);
                cyc(1'b0, OP_NONE, 10'h000);
                pat_chk;
                chk("after", rom_addr, 12'h03e);
            end
        end
        $display("test rows done");
        do_reset;
        far;
        acc = 4'h1;
        breg = 4'h0;
        carry = 1'b0;
        f = form(12'hd7f, 3'h0, 1'b0, 4'h0, 4'h1);
        w = {f[9:8], f[7:0] ^ 8'h5a};
        cyc(1'b1, OP_PATTERN, 10'h000);
        chk("bank1", rom_addr, f);
        // a jump offered during busy must be dropped
        cyc(1'b1, OP_LOCAL, 10'h000);
        pat_chk;
        chk("next", rom_addr, 12'hd7e);
        set_st0;
        bank_select_bit = 1'b1;
        cyc(1'b1, OP_PRELOAD, 10'h003);
        cyc(1'b0, OP_NONE, 10'h000);
        chk("pre_skip", rom_addr, 12'hd77);
        chk("pre_st", status, 1'b0);
        cyc(1'b1, OP_LOCAL, 10'h000);
        chk("br_skip", rom_addr, 12'hd6f);
        chk("br_st", status, 1'b1);
        set_st0;
        cyc(1'b1, OP_CALL, 10'h000);
        chk("cal_skip", rom_addr, 12'hd7c);
        chk("cal_st", status, 1'b1);
        chk("cal_slot", slot[0], 12'h000);
        set_st0;
        // an alu status write in the same cycle must be blocked
        status_in = 1'b1;
        status_load = 1'b1;
        cyc(1'b1, OP_TABLE, 10'h000);
        status_load = 1'b0;
        status_in = 1'b0;
        chk("tbr_pc", rom_addr, 12'hd41);
        chk("tbr_st", status, 1'b0);
        $display("test far pattern skip done");
        do_reset;
        far;
        cyc(1'b1, OP_CALL, 10'h03f);
        chk("cal_pc", rom_addr, 12'h03f);
        chk("cal_push", slot[0], 12'hd7e);
        cyc(1'b1, OP_CALL, 10'h03f);
        cyc(1'b0, OP_NONE, 10'h000);
        cyc(1'b1, OP_CALL, 10'h03f);
        cyc(1'b0, OP_NONE, 10'h000);
        cyc(1'b0, OP_NONE, 10'h000);
        cyc(1'b1, OP_CALL, 10'h03f);
        cyc(1'b1, OP_CALL, 10'h03f);
        foreach (es[i])
            chk("stack", slot[i], es[i]);
        rst_n = 1'b0;
        #1;
        chk("async_pc", rom_addr, 12'h03f);
        chk("async_slot", slot[0], 12'h000);
        @(posedge clk);
        #1;
        rst_n = 1'b1;
        $display("test calls done");
        report_and_stop;
    end
endmodule
